// ===== logic/sacp_pkg.sv
// Shared constants for the converter serial command port and its host
package sacp_pkg;
  localparam int RES_W     = 12;
  localparam int NCH_DEF   = 8;
  localparam int SEL_W     = 3;
  localparam int CMD_LEN   = 5;
  localparam int MSB_FIRST = 7;
  localparam int CLK_BASE  = 19;
  localparam int TAIL_CLKS = 12;
  localparam int K_W       = 6;
  localparam int LEAD_W    = 5;
  localparam int DIV_W     = 16;

  localparam int  CLK_PERIOD_NS = 8;
  localparam real ACC_LIMIT_MS  = 1.2;
  localparam int  ACC_CYC =
    int'(ACC_LIMIT_MS * 1.0e6) / CLK_PERIOD_NS;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_RES  = 8'h08;
  localparam logic [7:0] OFF_DIV  = 8'h0c;

  localparam int CTRL_GO       = 0;
  localparam int CTRL_MODE     = 1;
  localparam int CTRL_CH_LSB   = 2;
  localparam int CTRL_LEAD_LSB = 5;
  localparam int CTRL_TAIL     = 10;
  localparam int STAT_BUSY     = 0;
  localparam int STAT_DONE     = 1;
  localparam int STAT_LATE     = 2;
  localparam int RES_LSB_POS   = 16;

  localparam logic [DIV_W-1:0] DIV_RST  = 16'h000a;
  localparam logic [LEAD_W-1:0] LEAD_RST = 5'h00;
endpackage

// ===== logic/sacp_if.sv
// Serial link between converter port and its host
`timescale 1ns/1ps
interface sacp_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout_o;
  logic dout_oe;
  logic dout;

  // Released output reads low
  assign dout = dout_oe & dout_o;

  modport dev (input sclk, cs_n, din, output dout_o, dout_oe);
  modport host (output sclk, cs_n, din, input dout);
endinterface

// ===== logic/sacp_sync.sv
// Two-stage synchroniser with edge detection
`timescale 1ns/1ps
module sacp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sacp_sync_st_t;

  sacp_sync_st_t r;
  sacp_sync_st_t next_r;

  always_comb begin
    next_r    = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign q    = r.s2;
  assign rise = r.s2 & ~r.s3;
  assign fall = ~r.s2 & r.s3;
endmodule

// ===== logic/sacp_device.sv
// Converter end of the serial command port
//
// Overview of operation
// - Select high aborts and enters standby
// - Host raises select between transactions
// - Powered up selected: wait high-low toggle
// - First high input bit is start
// - Next bit: 1 single, 0 differential
// - Three select bits, high first, pick channel
// - Differential: pair, low bit picks polarity
// - Four-channel part ignores top select bit
// - Sampling starts fourth rise after start
// - Sampling ends fifth fall after start
// - One don't-care clock completes sample
// - Then a low null bit follows
// - Twelve result bits, MSB first
// - Output changes only on falling edges
// - Further clocks resend result LSB first
// - Then zeros while still selected
// - Leading zeros before start tolerated
// - Unsigned code, clamped at zero and full
// - Bias off after MSB-first result
// - Host reads result within 1.2 ms
`timescale 1ns/1ps
module sacp_device #(
  parameter int NCH = sacp_pkg::NCH_DEF
) (
  input  wire logic                        MCLK,
  input  wire logic                        NRST,
  input  wire logic                        CE,
  input  wire logic [NCH-1:0]
                    [sacp_pkg::RES_W-1:0]  AIN,
  output logic                             SAMPLING,
  output logic      [sacp_pkg::SEL_W-1:0]  POS_CH,
  output logic      [sacp_pkg::SEL_W-1:0]  NEG_CH,
  output logic                             DIFF_MODE,
  output logic                             CONV_ACTIVE,
  output logic                             STANDBY,
  output logic      [sacp_pkg::RES_W-1:0]  RESULT,
  output logic                             RESULT_STB,
  sacp_if.dev                              LINK
);
  localparam int RW = sacp_pkg::RES_W;
  localparam int SW = sacp_pkg::SEL_W;

  // ****************************************************
  // State
  // ****************************************************
  typedef enum logic [2:0] {
    S_STBY,
    S_IDLE,
    S_CFG,
    S_SAMP,
    S_MSB,
    S_LSB,
    S_ZERO
  } sacp_dst_t;

  typedef struct packed {
    sacp_dst_t       st;
    logic            armed;
    logic [3:0]      cnt;
    logic            mode;
    logic [SW-1:0]   sel;
    logic            samp;
    logic [RW-1:0]   code;
    logic            dout;
    logic            oe;
    logic            stb;
  } sacp_dev_t;

  sacp_dev_t r;
  sacp_dev_t next_r;

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic [2:0] pin_q;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  logic       cs_n;
  logic       din;
  logic       rise;
  logic       fall;

  sacp_sync #(
    .W (3)
  ) u_sync (
    .clk   (MCLK),
    .rst_n (NRST),
    .ce    (CE),
    .d     ({LINK.din, LINK.cs_n, LINK.sclk}),
    .q     (pin_q),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  assign cs_n = pin_q[1];
  assign din  = pin_q[2];
  assign rise = pin_rise[0];
  assign fall = pin_fall[0];

  // ****************************************************
  // Channel decode
  // ****************************************************
  // Top select bit masked on the four-channel part
  function automatic logic [SW-1:0] eff_sel(
    input logic [SW-1:0] s
  );
    logic [SW-1:0] e;
    e = s;
    if (NCH <= 4) begin
      e[SW-1] = 1'b0;
    end
    return e;
  endfunction

  logic [SW-1:0] pos_ch;
  logic [SW-1:0] neg_ch;
  logic [RW-1:0] pos_v;
  logic [RW-1:0] neg_v;
  logic [RW-1:0] conv;

  // Positive is the select value in both modes
  assign pos_ch = eff_sel(r.sel);
  // Partner of the pair takes the negative side
  assign neg_ch = eff_sel(r.sel) ^ SW'(1);
  assign pos_v  = AIN[pos_ch];
  assign neg_v  = AIN[neg_ch];

  always_comb begin
    if (r.mode) begin
      conv = pos_v;
    end else if (pos_v > neg_v) begin
      conv = pos_v - neg_v;
    end else begin
      conv = '0;
    end
  end

  // ****************************************************
  // Transaction sequencer
  // ****************************************************
  always_comb begin
    next_r     = r;
    next_r.stb = 1'b0;
    if (cs_n) begin
      // Deselect aborts whatever is running
      next_r.st    = S_STBY;
      next_r.samp  = 1'b0;
      next_r.oe    = 1'b0;
      next_r.dout  = 1'b0;
      next_r.armed = 1'b1;
    end else begin
      case (r.st)
        S_STBY: begin
          if (r.armed) begin
            next_r.st = S_IDLE;
          end
        end
        S_IDLE: begin
          if (rise && din) begin
            next_r.st  = S_CFG;
            next_r.cnt = '0;
          end
        end
        S_CFG: begin
          if (rise) begin
            if (r.cnt == 4'h0) begin
              next_r.mode = din;
            end else begin
              next_r.sel = {r.sel[SW-2:0], din};
            end
            next_r.cnt = r.cnt + 4'h1;
            if (r.cnt == 4'(SW)) begin
              next_r.st   = S_SAMP;
              next_r.samp = 1'b1;
              next_r.cnt  = '0;
            end
          end
        end
        S_SAMP: begin
          // Input level ignored on this clock
          if (rise) begin
            next_r.cnt = 4'h1;
          end
          if (fall && r.cnt == 4'h1) begin
            next_r.samp = 1'b0;
            next_r.code = conv;
            next_r.stb  = 1'b1;
            next_r.oe   = 1'b1;
            next_r.dout = 1'b0;
            next_r.cnt  = 4'(RW - 1);
            next_r.st   = S_MSB;
          end
        end
        S_MSB: begin
          if (fall) begin
            next_r.dout = r.code[r.cnt];
            if (r.cnt == 4'h0) begin
              next_r.st = S_LSB;
            end else begin
              next_r.cnt = r.cnt - 4'h1;
            end
          end
        end
        S_LSB: begin
          if (fall) begin
            next_r.dout = r.code[r.cnt];
            if (r.cnt == 4'(RW - 1)) begin
              next_r.st = S_ZERO;
            end else begin
              next_r.cnt = r.cnt + 4'h1;
            end
          end
        end
        S_ZERO: begin
          if (fall) begin
            next_r.dout = 1'b0;
          end
        end
        default: begin
          next_r.st = S_STBY;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      r    <= '0;
      r.st <= S_STBY;
    end else if (CE) begin
      r <= next_r;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign SAMPLING    = r.samp;
  assign POS_CH      = pos_ch;
  assign NEG_CH      = neg_ch;
  assign DIFF_MODE   = ~r.mode;
  // Comparator and bias only until MSB-first ends
  assign CONV_ACTIVE = (r.st == S_SAMP) || (r.st == S_MSB);
  assign STANDBY     = (r.st == S_STBY);
  assign RESULT      = r.code;
  assign RESULT_STB  = r.stb;
  assign LINK.dout_o  = r.dout;
  assign LINK.dout_oe = r.oe;
endmodule

// ===== logic/sacp_host.sv
// Host end: APB-controlled serial master for the converter
`timescale 1ns/1ps
module sacp_host #(
  parameter int ACC_CYC = sacp_pkg::ACC_CYC
) (
  input  wire logic        MCLK,
  input  wire logic        NRST,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  sacp_if.host             LINK
);
  import sacp_pkg::*;
  localparam int AW = $clog2(ACC_CYC + 1);

  // ****************************************************
  // State
  // ****************************************************
  typedef enum logic [2:0] {
    H_IDLE,
    H_SETUP,
    H_LOW,
    H_HIGH,
    H_GAP
  } sacp_hst_t;

  typedef struct packed {
    sacp_hst_t          st;
    logic               cs_n;
    logic               sclk;
    logic               din;
    logic [DIV_W-1:0]   tmr;
    logic [K_W-1:0]     k;
    logic               mode;
    logic [SEL_W-1:0]   chan;
    logic [LEAD_W-1:0]  lead;
    logic               tail;
    logic [DIV_W-1:0]   div;
    logic               done;
    logic               late;
    logic               acc_run;
    logic [AW-1:0]      acc;
    logic [RES_W-1:0]   msb;
    logic [RES_W-1:0]   lsb;
    logic [31:0]        prdata;
  } sacp_host_st_t;

  sacp_host_st_t r;
  sacp_host_st_t next_r;
  logic          dout;

  sacp_sync #(
    .W (1)
  ) u_sync (
    .clk   (MCLK),
    .rst_n (NRST),
    .ce    (CE),
    .d     (LINK.dout),
    .q     (dout),
    .rise  (),
    .fall  ()
  );

  // Leading zeros, start, mode, three select bits, zeros
  function automatic logic cmd_bit(
    input logic [K_W-1:0]   k,
    input logic [LEAD_W-1:0] lead,
    input logic             mode,
    input logic [SEL_W-1:0] chan
  );
    logic [K_W-1:0] i;
    i = k - K_W'(lead);
    if (k < K_W'(lead)) begin
      return 1'b0;
    end
    case (i)
      6'h00:   return 1'b1;
      6'h01:   return mode;
      6'h02:   return chan[2];
      6'h03:   return chan[1];
      6'h04:   return chan[0];
      default: return 1'b0;
    endcase
  endfunction

  logic           wr;
  logic           mapped;
  logic           tick;
  logic [K_W-1:0] last_k;
  logic [K_W-1:0] j;

  assign wr     = PSEL & PENABLE & PWRITE;
  assign mapped = (PADDR == OFF_CTRL) || (PADDR == OFF_STAT) ||
                  (PADDR == OFF_RES) || (PADDR == OFF_DIV);
  assign tick   = (r.tmr == '0);
  assign last_k = K_W'(r.lead) + K_W'(CLK_BASE - 1) +
                  (r.tail ? K_W'(TAIL_CLKS) : 6'h00);
  assign j      = r.k - K_W'(r.lead) - K_W'(MSB_FIRST);

  always_comb begin
    next_r = r;
    // ****************************************************
    // Register access
    // ****************************************************
    if (PSEL && !PENABLE) begin
      next_r.prdata = '0;
      case (PADDR)
        OFF_CTRL: begin
          next_r.prdata[CTRL_MODE] = r.mode;
          next_r.prdata[CTRL_CH_LSB +: SEL_W] = r.chan;
          next_r.prdata[CTRL_LEAD_LSB +: LEAD_W] = r.lead;
          next_r.prdata[CTRL_TAIL] = r.tail;
        end
        OFF_STAT: begin
          next_r.prdata[STAT_BUSY] = (r.st != H_IDLE);
          next_r.prdata[STAT_DONE] = r.done;
          next_r.prdata[STAT_LATE] = r.late;
        end
        OFF_RES: begin
          next_r.prdata[RES_W-1:0] = r.msb;
          next_r.prdata[RES_LSB_POS +: RES_W] = r.lsb;
        end
        OFF_DIV: next_r.prdata[DIV_W-1:0] = r.div;
        default: next_r.prdata = '0;
      endcase
    end
    if (wr && PADDR == OFF_STAT) begin
      next_r.done = r.done & ~PWDATA[STAT_DONE];
      next_r.late = r.late & ~PWDATA[STAT_LATE];
    end
    if (wr && PADDR == OFF_DIV) begin
      next_r.div = PWDATA[DIV_W-1:0];
    end
    // ****************************************************
    // Serial sequencer
    // ****************************************************
    if (r.st != H_IDLE) begin
      next_r.tmr = tick ? r.div - 16'h0001 : r.tmr - 16'h0001;
    end
    if (r.acc_run) begin
      next_r.acc = r.acc + AW'(1);
      if (r.acc == AW'(ACC_CYC)) begin
        next_r.late = 1'b1;
      end
    end
    case (r.st)
      H_IDLE: begin
        if (wr && PADDR == OFF_CTRL) begin
          next_r.mode = PWDATA[CTRL_MODE];
          next_r.chan = PWDATA[CTRL_CH_LSB +: SEL_W];
          next_r.lead = PWDATA[CTRL_LEAD_LSB +: LEAD_W];
          next_r.tail = PWDATA[CTRL_TAIL];
          if (PWDATA[CTRL_GO]) begin
            next_r.st   = H_SETUP;
            next_r.cs_n = 1'b0;
            next_r.tmr  = r.div - 16'h0001;
            next_r.k    = '0;
            next_r.msb  = '0;
            next_r.lsb  = '0;
          end
        end
      end
      H_SETUP: begin
        if (tick) begin
          next_r.st  = H_LOW;
          next_r.din = cmd_bit(r.k, r.lead, r.mode, r.chan);
        end
      end
      H_LOW: begin
        if (tick) begin
          // Bit sent on the previous fall is taken here
          if (r.k >= K_W'(r.lead) + K_W'(MSB_FIRST)) begin
            if (j < K_W'(RES_W)) begin
              next_r.msb = {r.msb[RES_W-2:0], dout};
            end else if (j < K_W'(2 * RES_W)) begin
              next_r.lsb = {dout, r.lsb[RES_W-1:1]};
            end
          end
          if (j == K_W'(RES_W - 1)) begin
            next_r.acc_run = 1'b0;
          end
          next_r.sclk = 1'b1;
          next_r.st   = H_HIGH;
        end
      end
      H_HIGH: begin
        if (tick) begin
          next_r.sclk = 1'b0;
          if (r.k == K_W'(r.lead) + K_W'(CMD_LEN)) begin
            next_r.acc_run = 1'b1;
            next_r.acc     = '0;
          end
          if (r.k == last_k) begin
            next_r.st   = H_GAP;
            next_r.cs_n = 1'b1;
            next_r.din  = 1'b0;
          end else begin
            next_r.k   = r.k + 6'h01;
            next_r.din = cmd_bit(r.k + 6'h01, r.lead, r.mode,
                                 r.chan);
            next_r.st  = H_LOW;
          end
        end
      end
      H_GAP: begin
        // Select held high for a half period
        if (tick) begin
          next_r.st   = H_IDLE;
          next_r.done = 1'b1;
        end
      end
      default: begin
        next_r.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      r      <= '0;
      r.st   <= H_IDLE;
      r.cs_n <= 1'b1;
      r.div  <= DIV_RST;
      r.lead <= LEAD_RST;
    end else if (CE) begin
      r <= next_r;
    end
  end

  assign PRDATA    = r.prdata;
  assign PREADY    = 1'b1;
  assign PSLVERR   = PSEL & PENABLE & ~mapped;
  assign LINK.sclk = r.sclk;
  assign LINK.cs_n = r.cs_n;
  assign LINK.din  = r.din;
endmodule

// ===== test/sacp_assertions.sv
// Checks on the serial link between host end and converter end
`timescale 1ns/1ps
module sacp_assertions (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic dout,
  input wire logic samp,
  input wire logic conv_on
);
  // ************************************************************
  // Frame tracking
  // ************************************************************
  logic       sclk_q;
  logic       started;
  logic [5:0] rs;
  logic [3:0] fc;
  logic       last_bit;
  logic       rise;

  // Rises counted from the start bit, cycles since last fall
  assign rise = sclk & ~sclk_q;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      sclk_q   <= 1'b0;
      started  <= 1'b0;
      rs       <= 6'h00;
      fc       <= 4'hf;
      last_bit <= 1'b0;
    end else begin
      sclk_q <= sclk;
      if (sclk_q & ~sclk) begin
        fc <= 4'h0;
      end else if (fc != 4'hf) begin
        fc <= fc + 4'h1;
      end
      if (cs_n) begin
        started <= 1'b0;
        rs      <= 6'h00;
      end else if (rise && (started || din)) begin
        started <= 1'b1;
        rs      <= rs + 6'h01;
      end
      if (rise) begin
        last_bit <= dout;
      end
    end
  end

  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  sequence s_deselect;
    $rose(cs_n);
  endsequence
  sequence s_null_slot;
    rise && rs == 6'd6;
  endsequence
  sequence s_copy_slot;
    rise && rs == 6'd19;
  endsequence

  abort_standby_a: assert property (
    s_deselect |-> ##[1:6] !dout_oe)
    else $error("output still driven after deselect");
  idle_release_a: assert property (
    cs_n [*6] |-> !dout_oe)
    else $error("output driven while deselected");
  deselect_gap_a: assert property (
    s_deselect |-> cs_n [*8])
    else $error("select low again too soon");
  clock_framed_a: assert property (
    $rose(sclk) |-> !cs_n && !$past(cs_n))
    else $error("serial clock outside a frame");
  fall_launch_a: assert property (
    ($changed(dout_o) && dout_oe && $past(dout_oe)) |-> fc <= 4'h6)
    else $error("output changed away from a falling edge");
  null_drive_a: assert property (
    $rose(dout_oe) |-> !dout_o && fc <= 4'h6)
    else $error("null bit not low at a falling edge");
  sample_count_a: assert property (
    $rose(dout_oe) |-> rs == 6'd6)
    else $error("null bit at wrong clock after start");
  null_sampled_a: assert property (
    s_null_slot |-> dout_oe && !dout)
    else $error("null bit not seen by host");
  lsb_repeat_a: assert property (
    s_copy_slot |-> dout == last_bit)
    else $error("copy does not begin with lowest bit");
  sample_open_a: assert property (
    $rose(samp) |-> rs == 6'd5)
    else $error("sampling not opened at fourth rise after start");
  sample_close_a: assert property (
    ($fell(samp) && !cs_n) |-> $rose(dout_oe))
    else $error("sampling not closed with the null bit");
  bias_off_a: assert property (
    ($fell(conv_on) && !cs_n) |-> rs == 6'd18)
    else $error("bias not off after most significant first word");
endmodule

// ===== test/tb.sv
// Bench: two host and converter pairs driven over APB
`timescale 1ns/1ps
module tb;
  logic             mclk, nrst, psel, psel4, penable, pwrite, err;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, prdata4, q;
  logic             pready, pready4, pslverr, pslverr4;
  logic             diff_mode, standby, sampling, conv_on;
  logic [2:0]       pos_ch, neg_ch;
  logic [11:0]      result;
  logic [7:0][11:0] ain;
  logic [3:0][11:0] ain4;
  int               n_errors, check_count;

  sacp_if link_a ();
  sacp_if link_b ();
  assign ain4 = ain[3:0];

  sacp_host u_sacp_host (.MCLK(mclk), .NRST(nrst), .CE(1'b1), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(link_a));
  sacp_device u_sacp_device (.MCLK(mclk), .NRST(nrst), .CE(1'b1), .AIN(ain),
    .SAMPLING(sampling), .POS_CH(pos_ch), .NEG_CH(neg_ch),
    .DIFF_MODE(diff_mode), .CONV_ACTIVE(conv_on), .STANDBY(standby),
    .RESULT(result), .RESULT_STB(), .LINK(link_a));
  sacp_host #(.ACC_CYC(200)) u_sacp_host_4ch (.MCLK(mclk), .NRST(nrst),
    .CE(1'b1), .PSEL(psel4), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata4), .PREADY(pready4),
    .PSLVERR(pslverr4), .LINK(link_b));
  sacp_device #(.NCH(4)) u_sacp_device_4ch (.MCLK(mclk), .NRST(nrst),
    .CE(1'b1), .AIN(ain4), .SAMPLING(), .POS_CH(), .NEG_CH(),
    .DIFF_MODE(), .CONV_ACTIVE(), .STANDBY(), .RESULT(), .RESULT_STB(),
    .LINK(link_b));
  sacp_assertions u_sacp_assertions (.MCLK(mclk), .NRST(nrst),
    .sclk(link_a.sclk), .cs_n(link_a.cs_n), .din(link_a.din),
    .dout_o(link_a.dout_o), .dout_oe(link_a.dout_oe), .dout(link_a.dout),
    .samp(sampling), .conv_on(conv_on));

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic four, input logic wr,
                     input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel    <= ~four;
    psel4   <= four;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while ((four ? pready4 : pready) !== 1'b1 && n < 16);
    q   = four ? prdata4 : prdata;
    err = four ? pslverr4 : pslverr;
    psel    <= 1'b0;
    psel4   <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      n_errors++;
      wrap_up();
    end
  endtask

  // Waits for done, clears it, leaves the result word in q
  task automatic fetch(input logic four);
    int i;
    for (i = 0; i < 1000; i++) begin
      apb(four, 1'b0, sacp_pkg::OFF_STAT, 32'h0);
      if (q[sacp_pkg::STAT_DONE] === 1'b1) break;
    end
    if (i == 1000) begin
      n_errors++;
      wrap_up();
    end
    apb(four, 1'b1, sacp_pkg::OFF_STAT, 32'h2);
    apb(four, 1'b0, sacp_pkg::OFF_RES, 32'h0);
  endtask

  function automatic logic [31:0] cw(logic m, logic [2:0] c,
                                     logic [4:0] ld, logic t);
    logic [31:0] w;
    w = 32'h0;
    w[sacp_pkg::CTRL_GO] = 1'b1;
    w[sacp_pkg::CTRL_MODE] = m;
    w[sacp_pkg::CTRL_CH_LSB+:3] = c;
    w[sacp_pkg::CTRL_LEAD_LSB+:5] = ld;
    w[sacp_pkg::CTRL_TAIL] = t;
    return w;
  endfunction

  // Single: selected code; pair: clamped difference
  function automatic logic [11:0] expv(logic m, logic [2:0] c, logic f);
    logic [2:0] s;
    s = f ? {1'b0, c[1:0]} : c;
    if (m) return ain[s];
    return (ain[s] > ain[s ^ 3'd1]) ? ain[s] - ain[s ^ 3'd1] : 12'h000;
  endfunction

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial begin
    {nrst, psel, psel4, penable, pwrite, paddr, pwdata} = '0;
    n_errors = 0;
    check_count = 0;
    ain = {12'h555, 12'hfff, 12'h001, 12'h000,
           12'h7ff, 12'h800, 12'h0f0, 12'h123};
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    apb(1'b0, 1'b0, sacp_pkg::OFF_DIV, 32'h0);
    chk(q, 32'h0000000a);
    apb(1'b0, 1'b0, sacp_pkg::OFF_STAT, 32'h0);
    chk({standby, q[30:0]}, 32'h80000000);
    apb(1'b0, 1'b0, 8'h10, 32'h0);
    chk({err, q[30:0]}, 32'h80000000);
    $display("test registers done");
    for (int c = 0; c < 8; c++) begin
      apb(1'b0, 1'b1, sacp_pkg::OFF_CTRL, cw(1'b1, 3'(c),
          (c == 7) ? 5'd31 : 5'(c * 3), 1'b0));
      fetch(1'b0);
      chk(q[11:0], expv(1'b1, 3'(c), 1'b0));
      chk(result, expv(1'b1, 3'(c), 1'b0));
      chk({diff_mode, pos_ch}, {1'b0, 3'(c)});
    end
    $display("test single-ended done");
    for (int c = 0; c < 8; c++) begin
      apb(1'b0, 1'b1, sacp_pkg::OFF_CTRL, cw(1'b0, 3'(c), 5'd2, 1'b1));
      fetch(1'b0);
      chk(q[11:0], expv(1'b0, 3'(c), 1'b0));
      chk(q[27:16], expv(1'b0, 3'(c), 1'b0));
      chk({diff_mode, pos_ch, neg_ch}, {1'b1, 3'(c), 3'(c ^ 1)});
      chk(standby, 1'b1);
    end
    $display("test differential done");
    apb(1'b0, 1'b1, sacp_pkg::OFF_CTRL, cw(1'b1, 3'd6, 5'd0, 1'b0));
    apb(1'b0, 1'b1, sacp_pkg::OFF_CTRL, cw(1'b1, 3'd1, 5'd0, 1'b0));
    fetch(1'b0);
    chk(q[11:0], 12'hfff);
    apb(1'b0, 1'b0, sacp_pkg::OFF_STAT, 32'h0);
    chk(q[2:0], 3'b000);
    $display("test busy refusal done");
    apb(1'b1, 1'b1, sacp_pkg::OFF_CTRL, cw(1'b1, 3'd6, 5'd5, 1'b0));
    fetch(1'b1);
    chk(q[11:0], expv(1'b1, 3'd6, 1'b1));
    apb(1'b1, 1'b0, sacp_pkg::OFF_STAT, 32'h0);
    chk(q[2:0], 3'b100);
    apb(1'b1, 1'b1, sacp_pkg::OFF_CTRL, cw(1'b0, 3'd6, 5'd0, 1'b0));
    fetch(1'b1);
    chk(q[11:0], expv(1'b0, 3'd6, 1'b1));
    $display("test four-channel done");
    wrap_up();
  end
endmodule
